// ### dv/reset_source_controller_test.sv
// self-checking bench of the reset source controller
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module reset_source_controller_test;
    import rsc_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk, rst_n, low_sup, sleep, wdt_ovf, halt, clr_wdt;
    reg_req_s req;
    logic [7:0] rdata;
    logic core_n, preset, pc_sp, wdt_clr, lvs_en, tmo, pwrdn, irq;
    int failures, n_compared, n;
    reset_source_controller i_reset_source_controller (.CLOCK_I(clk),
        .RST_N_I(rst_n), .REG_REQ_I(req), .RDATA_O(rdata),
        .LOW_SUPPLY_I(low_sup), .SLEEP_MODE_I(sleep),
        .WDT_OVERFLOW_I(wdt_ovf), .HALT_EXEC_I(halt), .CLR_WDT_I(clr_wdt),
        .CORE_RST_N_O(core_n), .PORT_PRESET_O(preset), .PC_SP_CLR_O(pc_sp),
        .WDT_CLR_O(wdt_clr), .LVS_EN_O(lvs_en), .TIMEOUT_O(tmo),
        .PWRDN_O(pwrdn), .IRQ_O(irq));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task summarize;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    task reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '{4'h0, 8'h00, 1'b0, 1'b0};
        #1;
    endtask : reg_wr
    // read data stand one cycle only, then fall to zero
    task reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '{4'h0, 8'h00, 1'b0, 1'b0};
        #1;
        `CHK(rdata, e)
        @(posedge clk);
        #1;
        `CHK(rdata, 8'h00)
    endtask : reg_rd
    // bounded wait for the core reset to reach a level
    task wait_core(input logic lvl);
        n = 0;
        while (core_n !== lvl)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > 3000)
            begin
                failures++;
                summarize();
            end
        end
    endtask : wait_core
    task pulse(input int k);
        @(posedge clk);
        case (k)
            0: halt <= 1'b1;
            1: clr_wdt <= 1'b1;
            default: wdt_ovf <= 1'b1;
        endcase
        @(posedge clk);
        {halt, clr_wdt, wdt_ovf} <= 3'h0;
        #1;
    endtask : pulse
    // ****************************************
    // scenarios
    // ****************************************
    task t_por;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK({core_n, preset, lvs_en, tmo, pwrdn}, 5'h0C)
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        wait_core(1'b1);
        `CHK(n, HOLD_CYC)
        `CHK(wdt_clr, 1'b1)
        @(posedge clk);
        #1;
        `CHK({preset, wdt_clr}, 2'h0)
    endtask : t_por
    task t_regs;
        reg_wr(ADDR_FLAGS, 8'hFF);
        reg_rd(ADDR_FLAGS, 8'h00);
        reg_rd(ADDR_CORE_STAT, 8'h00);
        reg_rd(ADDR_IRQ_EN, 8'h00);
        reg_wr(4'hF, 8'hFF);
        reg_rd(4'hF, 8'h00);
    endtask : t_regs
    task t_flash_irq;
        reg_wr(ADDR_IRQ_EN, 8'h04);
        reg_wr(ADDR_FLASH_CTRL, FLASH_TRIGGER);
        `CHK({core_n, preset}, 2'h1)
        wait_core(1'b1);
        `CHK(n, HOLD_CYC)
        `CHK(irq, 1'b1)
        reg_rd(ADDR_FLASH_CTRL, 8'h00);
        reg_rd(ADDR_IRQ_STAT, 8'h04);
        reg_wr(ADDR_IRQ_EN, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        reg_wr(ADDR_IRQ_EN, 8'h04);
        reg_wr(ADDR_IRQ_CLR, 8'h04);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        reg_rd(ADDR_IRQ_STAT, 8'h00);
    endtask : t_flash_irq
    task t_sw_wdt;
        reg_wr(ADDR_WDT_CTRL, {WDT_EN_B, 3'h3});
        reg_rd(ADDR_WDT_CTRL, 8'hAB);
        reg_wr(ADDR_WDT_CTRL, WDT_CTRL_RST);
        `CHK(core_n, 1'b1)
        reg_wr(ADDR_WDT_CTRL, 8'h00);
        `CHK(core_n, 1'b0)
        wait_core(1'b1);
        reg_rd(ADDR_WDT_CTRL, WDT_CTRL_RST);
        reg_rd(ADDR_FLAGS, 8'h01);
        reg_wr(ADDR_FLAGS, 8'h00);
        reg_rd(ADDR_FLAGS, 8'h00);
    endtask : t_sw_wdt
    task t_halt;
        pulse(0);
        `CHK(pwrdn, 1'b1)
        pulse(1);
        `CHK(pwrdn, 1'b0)
        pulse(0);
    endtask : t_halt
    // a drop one cycle short of qualifying must be ignored
    task t_low_volt;
        @(posedge clk);
        low_sup <= 1'b1;
        repeat (LVR_QUAL_CYC) @(posedge clk);
        low_sup <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(core_n, 1'b1)
        @(posedge clk);
        low_sup <= 1'b1;
        #1;
        wait_core(1'b0);
        // reset lands on the first edge after the qualify time
        `CHK(n, LVR_QUAL_CYC + 1)
        @(posedge clk);
        low_sup <= 1'b0;
        #1;
        wait_core(1'b1);
        reg_rd(ADDR_FLAGS, 8'h04);
        `CHK({tmo, pwrdn}, 2'h1)
        reg_wr(ADDR_FLAGS, 8'hFF);
        reg_rd(ADDR_FLAGS, 8'h04);
        reg_wr(ADDR_FLAGS, 8'h00);
        reg_rd(ADDR_FLAGS, 8'h00);
    endtask : t_low_volt
    task t_sleep_wdt;
        pulse(1);
        @(posedge clk);
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(lvs_en, 1'b0)
        pulse(2);
        `CHK({pc_sp, wdt_clr, tmo, pwrdn}, 4'hF)
        `CHK({core_n, preset}, 2'h2)
        @(posedge clk);
        sleep <= 1'b0;
        #1;
        `CHK(pc_sp, 1'b0)
        repeat (2) @(posedge clk);
        #1;
        `CHK(lvs_en, 1'b1)
        // lv, sw watchdog and sleep overflow all left sticky bits
        reg_rd(ADDR_IRQ_STAT, 8'h13);
    endtask : t_sleep_wdt
    task t_run_wdt;
        `CHK({tmo, pwrdn}, 2'h0)
        pulse(2);
        wait_core(1'b0);
        `CHK({tmo, pwrdn, preset}, 3'h5)
        wait_core(1'b1);
        `CHK(tmo, 1'b1)
        reg_rd(ADDR_IRQ_STAT, 8'h08);
    endtask : t_run_wdt
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        {low_sup, sleep, wdt_ovf, halt, clr_wdt} = 5'h00;
        req = '{4'h0, 8'h00, 1'b0, 1'b0};
        failures = 0;
        n_compared = 0;
        t_por();
        t_regs();
        t_flash_irq();
        t_sw_wdt();
        t_halt();
        t_low_volt();
        t_sleep_wdt();
        t_por();
        t_run_wdt();
        summarize();
    end
endmodule : reset_source_controller_test

// ### inc/rsc_pkg.sv
// constants, types and register map of the reset source controller
// How it works
// [RULE1] power-on holds core, then program counter zero
// [RULE2] power-up loads port data, direction to ones
// [RULE3] low-voltage supervisor always on while running
// [RULE4] only long low-supply episodes cause reset
// [RULE5] qualified low-voltage reset sets its flag
// [RULE6] low-voltage flag cleared only by software zero
// [RULE7] supervisor disabled in sleep or idle
// [RULE8] unused flag bits 7..3 and 1 read zero
// [RULE9] trigger 55H in flash control resets device
// [RULE10] running watchdog overflow: full reset, time-out set
// [RULE11] sleeping watchdog overflow clears only counter, stack; code also pulses WDT_CLR_O
// [RULE12] status bits follow each reset cause
// [RULE13] power-on leaves every interrupt disabled
// [RULE14] reset clears watchdog, time bases; watchdog counts
// [RULE15] power-on switches all timer modules off
// [RULE16] power-on leaves stack pointer at top
// [RULE17] watchdog control reset sets flag; software clears
// [RULE18] halt sets power-down; power-up, clear-watchdog clear
// [RULE19] core reset asserts asynchronously, releases synchronously
package rsc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_FLASH_CTRL = 4'h1;
    localparam logic [3:0] ADDR_WDT_CTRL = 4'h2;
    localparam logic [3:0] ADDR_CORE_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
    // ****************************************
    // fields and values
    // ****************************************
    localparam int FLAG_LV_BIT = 2;
    localparam int FLAG_SW_BIT = 0;
    localparam int STAT_TO_BIT = 1;
    localparam int STAT_PD_BIT = 0;
    localparam logic [7:0] FLASH_TRIGGER = 8'h55;
    localparam logic [7:0] WDT_CTRL_RST = 8'h53;
    localparam logic [4:0] WDT_EN_A = 5'h0A;
    localparam logic [4:0] WDT_EN_B = 5'h15;
    // event bits: lv, sw watchdog, flash, wdt run, wdt sleep
    localparam int NUM_EVT = 5;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int POR_SETTLE_NS = 1000;
    localparam int HOLD_CYC = (POR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int LVR_QUAL_NS = 10000;
    localparam int LVR_QUAL_CYC = (LVR_QUAL_NS + CLK_NS - 1) / CLK_NS;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef enum logic {ST_HOLD, ST_RUN} seq_state_e;
endpackage : rsc_pkg

// ### verilog/reset_source_controller.sv
// reset source combiner with cause flags and status bits
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module reset_source_controller
(
    // clock and power-on reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // register port
    input wire rsc_pkg::reg_req_s REG_REQ_I,
    output logic [7:0] RDATA_O,
    // core events
    input wire logic LOW_SUPPLY_I,
    input wire logic SLEEP_MODE_I,
    input wire logic WDT_OVERFLOW_I,
    input wire logic HALT_EXEC_I,
    input wire logic CLR_WDT_I,
    // reset outputs
    output logic CORE_RST_N_O,
    output logic PORT_PRESET_O,
    output logic PC_SP_CLR_O,
    output logic WDT_CLR_O,
    output logic LVS_EN_O,
    // status and interrupt
    output logic TIMEOUT_O,
    output logic PWRDN_O,
    output logic IRQ_O
);
    import rsc_pkg::*;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    logic wr_flags, wr_flash, wr_watchdog_control_register, wr_iclr, wr_ien;
    assign wr_flags = REG_REQ_I.wr && hit(REG_REQ_I.addr, ADDR_FLAGS);
    assign wr_flash = REG_REQ_I.wr && hit(REG_REQ_I.addr, ADDR_FLASH_CTRL);
    assign wr_watchdog_control_register = REG_REQ_I.wr && hit(REG_REQ_I.addr, ADDR_WDT_CTRL);
    assign wr_iclr = REG_REQ_I.wr && hit(REG_REQ_I.addr, ADDR_IRQ_CLR);
    assign wr_ien = REG_REQ_I.wr && hit(REG_REQ_I.addr, ADDR_IRQ_EN);

    // ****************************************
    // low-voltage qualification
    // ****************************************
    logic [15:0] lv_cnt_r;
    logic lv_evt;
    logic lvs_en_r;
    // [RULE3] supervisor active in running modes
    assign LVS_EN_O = lvs_en_r;
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            lvs_en_r <= 1'b1;
        else
            // [RULE7] off in sleep or idle
            lvs_en_r <= !SLEEP_MODE_I;
    end

    // [RULE4] count must exceed the qualify time
    assign lv_evt = LOW_SUPPLY_I && !SLEEP_MODE_I
        && (lv_cnt_r == 16'(LVR_QUAL_CYC));
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            lv_cnt_r <= 16'h0000;
        else if (!LOW_SUPPLY_I || SLEEP_MODE_I)
            lv_cnt_r <= 16'h0000;
        else if (lv_cnt_r <= 16'(LVR_QUAL_CYC))
            // saturates past the limit, one event per episode
            lv_cnt_r <= lv_cnt_r + 16'h0001;
    end

    // ****************************************
    // reset requests
    // ****************************************
    logic [7:0] flash_ctrl_r, watchdog_control_register_r;
    logic flash_evt, sw_evt, wdt_run_evt, wdt_slp_evt, full_req;
    logic core_rst_n_r;
    // [RULE9] trigger value starts a full reset
    assign flash_evt = wr_flash && (REG_REQ_I.wdata == FLASH_TRIGGER);
    // [RULE17] bad enable field is a software reset
    assign sw_evt = wr_watchdog_control_register && (REG_REQ_I.wdata[7:3] != WDT_EN_A)
        && (REG_REQ_I.wdata[7:3] != WDT_EN_B);
    // [RULE10] running overflow acts as power-on
    assign wdt_run_evt = WDT_OVERFLOW_I && !SLEEP_MODE_I;
    // core held in reset cannot be asleep
    assign wdt_slp_evt = WDT_OVERFLOW_I && SLEEP_MODE_I && core_rst_n_r;
    assign full_req = lv_evt || flash_evt || sw_evt || wdt_run_evt;

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            flash_ctrl_r <= 8'h00;
            watchdog_control_register_r <= WDT_CTRL_RST;
        end
        else if (!core_rst_n_r)
        begin
            flash_ctrl_r <= 8'h00;
            watchdog_control_register_r <= WDT_CTRL_RST;
        end
        else
        begin
            if (wr_flash)
                flash_ctrl_r <= REG_REQ_I.wdata;
            if (wr_watchdog_control_register)
                watchdog_control_register_r <= REG_REQ_I.wdata;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_e state_r;
    logic [15:0] hold_cnt_r;
    logic core_rel;
    assign core_rel = (state_r == ST_HOLD)
        && (hold_cnt_r == 16'(HOLD_CYC - 1)) && !full_req;

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_r <= ST_HOLD;
            hold_cnt_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                ST_HOLD:
                begin
                    if (full_req)
                        hold_cnt_r <= 16'h0000;
                    else if (core_rel)
                        state_r <= ST_RUN;
                    else
                        hold_cnt_r <= hold_cnt_r + 16'h0001;
                end
                ST_RUN:
                begin
                    hold_cnt_r <= 16'h0000;
                    if (full_req)
                        state_r <= ST_HOLD;
                end
                default:
                    state_r <= ST_HOLD;
            endcase
        end
    end

    // [RULE19] async assert, release on a clock edge
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            core_rst_n_r <= 1'b0;
        else if (full_req)
            core_rst_n_r <= 1'b0;
        // [RULE1] released only after settling delay
        else if (core_rel)
            core_rst_n_r <= 1'b1;
    end
    // [RULE13] [RULE15] [RULE16] core reset clears ints, timers, stack
    assign CORE_RST_N_O = core_rst_n_r;

    logic port_preset_r, pc_sp_clr_r, wdt_clr_r;
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            port_preset_r <= 1'b1;
            pc_sp_clr_r <= 1'b0;
            wdt_clr_r <= 1'b0;
        end
        else
        begin
            // [RULE2] ports forced to inputs while held
            port_preset_r <= full_req || (!core_rst_n_r && !core_rel);
            // [RULE11] sleeping overflow clears pc and stack, and pulses the watchdog clear
            pc_sp_clr_r <= wdt_slp_evt;
            // [RULE14] watchdog, time bases cleared at every reset
            wdt_clr_r <= core_rel || wdt_slp_evt;
        end
    end
    assign PORT_PRESET_O = port_preset_r;
    assign PC_SP_CLR_O = pc_sp_clr_r;
    assign WDT_CLR_O = wdt_clr_r;

    // ****************************************
    // cause flags and status bits
    // ****************************************
    logic lv_flag_r, sw_flag_r, to_r, pd_r;
    // set wins over a software clear in the same cycle
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lv_flag_r <= 1'b0;
            sw_flag_r <= 1'b0;
        end
        else
        begin
            // [RULE5] [RULE6] set by hardware, cleared by software
            if (lv_evt)
                lv_flag_r <= 1'b1;
            else if (wr_flags && !REG_REQ_I.wdata[FLAG_LV_BIT])
                lv_flag_r <= 1'b0;
            // [RULE17] sticky software watchdog flag
            if (sw_evt)
                sw_flag_r <= 1'b1;
            else if (wr_flags && !REG_REQ_I.wdata[FLAG_SW_BIT])
                sw_flag_r <= 1'b0;
        end
    end

    // [RULE12] power-on clears both; lv reset leaves them
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            to_r <= 1'b0;
            pd_r <= 1'b0;
        end
        else
        begin
            if (WDT_OVERFLOW_I)
                to_r <= 1'b1;
            // [RULE18] halt sets, clear-watchdog clears
            if (wdt_slp_evt || HALT_EXEC_I)
                pd_r <= 1'b1;
            else if (CLR_WDT_I)
                pd_r <= 1'b0;
        end
    end
    assign TIMEOUT_O = to_r;
    assign PWRDN_O = pd_r;

    // ****************************************
    // interrupt
    // ****************************************
    logic [NUM_EVT-1:0] irq_stat_r, irq_en_r, evt_vec;
    logic irq_r;
    assign evt_vec = {wdt_slp_evt, wdt_run_evt, flash_evt, sw_evt, lv_evt};
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            irq_stat_r <= '0;
            irq_en_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_stat_r <= evt_vec | (irq_stat_r
                & ~(wr_iclr ? REG_REQ_I.wdata[NUM_EVT-1:0] : '0));
            if (wr_ien)
                irq_en_r <= REG_REQ_I.wdata[NUM_EVT-1:0];
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end
    assign IRQ_O = irq_r;

    // ****************************************
    // read port
    // ****************************************
    logic [7:0] rdata_r, rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        case (REG_REQ_I.addr)
            // [RULE8] unused bits read zero
            ADDR_FLAGS: rd_mux = {5'h00, lv_flag_r, 1'b0, sw_flag_r};
            ADDR_FLASH_CTRL: rd_mux = flash_ctrl_r;
            ADDR_WDT_CTRL: rd_mux = watchdog_control_register_r;
            ADDR_CORE_STAT: rd_mux = {6'h00, to_r, pd_r};
            ADDR_IRQ_STAT: rd_mux = {3'h0, irq_stat_r};
            ADDR_IRQ_EN: rd_mux = {3'h0, irq_en_r};
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rdata_r <= 8'h00;
        else if (REG_REQ_I.rd)
            rdata_r <= rd_mux;
        else
            rdata_r <= 8'h00;
    end
    assign RDATA_O = rdata_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_slp_ovf;
        WDT_OVERFLOW_I && SLEEP_MODE_I && CORE_RST_N_O;
    endsequence
    sequence s_slp_eff;
        PC_SP_CLR_O && TIMEOUT_O && PWRDN_O && CORE_RST_N_O;
    endsequence

    property p_por_hold;
        $rose(state_r == ST_HOLD) |-> !CORE_RST_N_O [*8];
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("early release"); // [RULE1]
    property p_lv_qual;
        LOW_SUPPLY_I && !SLEEP_MODE_I && lv_cnt_r == 16'h0000
            |-> !lv_evt [*8];
    endproperty
    a_lv_qual: assert property (p_lv_qual) else $error("short dip reset"); // [RULE4]
    property p_lv_flag;
        lv_evt |=> lv_flag_r && !CORE_RST_N_O;
    endproperty
    a_lv_flag: assert property (p_lv_flag) else $error("lv flag not set"); // [RULE5]
    property p_lv_keep;
        lv_flag_r && !wr_flags |=> lv_flag_r;
    endproperty
    a_lv_keep: assert property (p_lv_keep) else $error("lv flag lost"); // [RULE6]
    property p_lvs_off;
        SLEEP_MODE_I |=> !LVS_EN_O;
    endproperty
    a_lvs_off: assert property (p_lvs_off) else $error("lvs on in sleep"); // [RULE7]
    property p_rsvd;
        REG_REQ_I.rd && REG_REQ_I.addr == ADDR_FLAGS
            |=> RDATA_O[7:3] == 5'h00 && !RDATA_O[1];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // [RULE8]
    property p_flash;
        wr_flash && REG_REQ_I.wdata == FLASH_TRIGGER
            |=> !CORE_RST_N_O && PORT_PRESET_O;
    endproperty
    a_flash: assert property (p_flash) else $error("no flash reset"); // [RULE9]
    property p_wdt_run;
        WDT_OVERFLOW_I && !SLEEP_MODE_I |=> TIMEOUT_O && !CORE_RST_N_O;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("run wdt wrong"); // [RULE10]
    property p_wdt_slp;
        s_slp_ovf |=> s_slp_eff;
    endproperty
    a_wdt_slp: assert property (p_wdt_slp) else $error("sleep wdt wrong"); // [RULE11]
    property p_halt;
        HALT_EXEC_I |=> PWRDN_O;
    endproperty
    a_halt: assert property (p_halt) else $error("pd not set"); // [RULE18]
    property p_sw;
        sw_evt |=> sw_flag_r && !CORE_RST_N_O;
    endproperty
    a_sw: assert property (p_sw) else $error("sw flag not set"); // [RULE17]
endmodule : reset_source_controller
